//--- tshsp_pkg.sv
// Shared constants, types and helpers for the touch sensor host serial port
package tshsp_pkg;

  localparam int ADDR_W   = 7;
  localparam int DATA_W   = 8;
  localparam int CHANNELS = 8;

  // Two-wire slave addresses chosen by the address select pin
  localparam logic [6:0] SLAVE_ADDR_LO = 7'h16;
  localparam logic [6:0] SLAVE_ADDR_HI = 7'h17;

  // Bit counter landmarks (counted on clock rises)
  localparam logic [3:0] CNT_ZERO   = 4'h0;
  localparam logic [3:0] CNT_SPI_LAST = 4'h7;
  localparam logic [3:0] CNT_BYTE   = 4'h8;
  localparam logic [3:0] CNT_ACK    = 4'h9;

  // Four-wire command byte: read flag on top, register address below
  localparam int SPI_RW_BIT = 7;

  // Power-on reset timing
  localparam int CLK_MHZ     = 50;
  localparam int POR_TIME_US = 100;
  localparam int POR_CNT_W   = 16;

  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_REG, I_WDATA, I_RDATA, I_IGNORE
  } tshsp_i2c_st_t;

  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } tshsp_wr_t;

  // Register pointer auto-increment, wraps at the top of the space
  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a);
    next_addr = a + 7'h01;
  endfunction

endpackage

//--- tshsp_regmem.sv
// Register space storage with registered read data
`timescale 1ns/1ns
module tshsp_regmem
  import tshsp_pkg::*;
(
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        srst,
  // Write port
  input  wire tshsp_pkg::tshsp_wr_t        wr,
  // Read port
  input  wire logic [tshsp_pkg::ADDR_W-1:0] rd_addr,
  output logic      [tshsp_pkg::DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge clk)
  begin
    if (wr.en)
      mem[wr.addr] <= wr.data;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      rd_data <= 8'h00;
    else
      rd_data <= mem[rd_addr];
  end
endmodule // tshsp_regmem

//--- tshsp_top.sv
// Host serial port: two-wire / four-wire slave, reset release and results
`timescale 1ns/1ns
module tshsp_top
  import tshsp_pkg::*;
#(
  parameter int POR_CYCLES = POR_TIME_US * CLK_MHZ
)
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  external_reset_n,
  // Serial pins
  input  wire logic                  scl_sck,
  input  wire logic                  sda_si_in,
  output logic                       sda_out,
  output logic                       sda_oe,
  input  wire logic                  address_select_pin,
  output logic                       so_out,
  output logic                       so_oe,
  input  wire logic                  iface_select_chip_select_n,
  // Measurement core
  input  wire logic                  meas_done,
  input  wire logic                  meas_start,
  input  wire logic [CHANNELS-1:0]   channel_judgment,
  input  wire logic                  error_status,
  // Device outputs
  output logic                       measurement_done_irq,
  output logic [CHANNELS-1:0]        channel_result_output,
  output logic [CHANNELS-1:0]        channel_result_oe,
  output logic                       error_out,
  output logic                       error_oe,
  output logic                       sense_drive_en
);
  import tshsp_pkg::*;

  localparam logic [POR_CNT_W-1:0] POR_LAST =
    POR_CNT_W'(POR_CYCLES - 1);

  // Pin synchronisers: scl, sda, cs_n, sa, reset_n
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [2:0] prev;
  logic       por_busy;
  logic [POR_CNT_W-1:0] por_cnt;
  logic       spi_mode;
  tshsp_i2c_st_t state;
  logic [3:0] cnt;
  logic [DATA_W-1:0] sh;
  logic [DATA_W-1:0] tx;
  logic       tx_en;
  logic       ack_drive;
  logic       rw;
  logic       mack;
  logic       first;
  logic [ADDR_W-1:0] ptr;
  tshsp_wr_t  wr;
  logic [DATA_W-1:0] rd_data;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sync1 <= 5'h1F;
      sync2 <= 5'h1F;
      prev  <= 3'h7;
    end
    else
    begin
      sync1 <= {external_reset_n, address_select_pin,
                iface_select_chip_select_n, sda_si_in, scl_sck};
      sync2 <= sync1;
      prev  <= sync2[2:0];
    end
  end

  wire scl_s    = sync2[0];
  wire sda_s    = sync2[1];
  wire cs_s     = sync2[2];
  wire sa_s     = sync2[3];
  wire rst_n_s  = sync2[4];
  wire scl_rise = scl_s & ~prev[0];
  wire scl_fall = ~scl_s & prev[0];
  wire cs_fall  = ~cs_s & prev[2];
  wire i2c_start = scl_s & prev[0] & ~sda_s & prev[1];
  wire i2c_stop  = scl_s & prev[0] & sda_s & ~prev[1];
  wire por_done = por_busy && por_cnt == POR_LAST;
  wire run      = ~por_busy & rst_n_s;
  wire hold     = srst | ~run;
  wire [6:0] own_addr = sa_s ? SLAVE_ADDR_HI : SLAVE_ADDR_LO;
  wire addr_hit = sh[7:1] == own_addr;
  wire [DATA_W-1:0] sh_in = {sh[6:0], sda_s};

  // Power-on reset timer; the interrupt output marks its release
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      por_busy <= 1'b1;
      por_cnt  <= '0;
      measurement_done_irq <= 1'b1;
    end
    else if (por_busy)
    begin
      por_cnt  <= por_cnt + 16'h0001;
      por_busy <= ~por_done;
      measurement_done_irq <= ~por_done;
    end
    else if (meas_done)
      measurement_done_irq <= 1'b1;
    else if (meas_start)
      measurement_done_irq <= 1'b0;
  end

  // Pins are released while reset holds; values then mean nothing
  always_ff @(posedge clk)
  begin
    if (hold)
    begin
      channel_result_output <= '0;
      channel_result_oe     <= '0;
      error_out             <= 1'b0;
      error_oe              <= 1'b0;
      sense_drive_en        <= 1'b0;
    end
    else
    begin
      channel_result_output <= channel_judgment;
      channel_result_oe     <= '1;
      error_out             <= error_status;
      error_oe              <= 1'b1;
      sense_drive_en        <= 1'b1;
    end
  end

  // Mode stays four-wire until the next reset
  always_ff @(posedge clk)
  begin
    if (hold)
      spi_mode <= 1'b0;
    else if (cs_fall)
      spi_mode <= 1'b1;
  end

  // Serial engine for both links; they never run at once
  always_ff @(posedge clk)
  begin
    wr.en <= 1'b0;
    if (hold)
    begin
      state <= I_IDLE;
      cnt <= CNT_ZERO;
      sh <= 8'h00;
      tx <= 8'h00;
      tx_en <= 1'b0;
      ack_drive <= 1'b0;
      rw <= 1'b0;
      mack <= 1'b0;
      first <= 1'b1;
      ptr <= '0;
      wr <= '0;
    end
    else if (spi_mode || cs_fall)
    begin
      if (cs_s || cs_fall)
      begin
        cnt <= CNT_ZERO;
        first <= 1'b1;
        tx <= 8'h00;
      end
      else if (scl_rise)
      begin
        sh <= sh_in;
        cnt <= (cnt == CNT_SPI_LAST) ? CNT_ZERO : cnt + 4'h1;
        if (cnt == CNT_SPI_LAST && first)
        begin
          first <= 1'b0;
          rw <= sh[SPI_RW_BIT-1];
          ptr <= sh_in[ADDR_W-1:0];
        end
        else if (cnt == CNT_SPI_LAST && !rw)
        begin
          wr <= '{1'b1, ptr, sh_in};
          ptr <= next_addr(ptr);
        end
      end
      else if (scl_fall && !first && rw)
      begin
        // Mode 0 and 3 both give a fall after each eighth rise that another byte follows
        if (cnt == CNT_ZERO)
        begin
          tx <= rd_data;
          ptr <= next_addr(ptr);
        end
        else
          tx <= {tx[6:0], 1'b0};
      end
    end
    else if (i2c_start)
    begin
      state <= I_ADDR;
      cnt <= CNT_ZERO;
      tx_en <= 1'b0;
      ack_drive <= 1'b0;
    end
    else if (i2c_stop)
    begin
      state <= I_IDLE;
      tx_en <= 1'b0;
      ack_drive <= 1'b0;
    end
    else if (state != I_IDLE && state != I_IGNORE)
    begin
      if (scl_rise)
      begin
        cnt <= cnt + 4'h1;
        if (cnt < CNT_BYTE && state != I_RDATA)
          sh <= sh_in;
        if (cnt == CNT_BYTE)
          mack <= sda_s;
      end
      else if (scl_fall && cnt == CNT_BYTE)
      begin
        unique case (state)
          I_ADDR:
            if (addr_hit)
            begin
              ack_drive <= 1'b1;
              rw <= sh[0];
            end
            else
              state <= I_IGNORE;
          I_REG:
          begin
            ack_drive <= 1'b1;
            ptr <= sh[ADDR_W-1:0];
          end
          I_WDATA:
          begin
            ack_drive <= 1'b1;
            wr <= '{1'b1, ptr, sh};
            ptr <= next_addr(ptr);
          end
          I_RDATA:
            tx_en <= 1'b0;
          default:
            tx_en <= 1'b0;
        endcase
      end
      else if (scl_fall && cnt == CNT_ACK)
      begin
        ack_drive <= 1'b0;
        cnt <= CNT_ZERO;
        unique case (state)
          I_ADDR:
          begin
            state <= rw ? I_RDATA : I_REG;
            tx <= rd_data;
            tx_en <= rw;
            if (rw)
              ptr <= next_addr(ptr);
          end
          I_REG:
            state <= I_WDATA;
          I_RDATA:
            if (mack)
              state <= I_IGNORE;
            else
            begin
              tx <= rd_data;
              tx_en <= 1'b1;
              ptr <= next_addr(ptr);
            end
          default:
            state <= state;
        endcase
      end
      else if (scl_fall && state == I_RDATA && cnt != CNT_ZERO)
        tx <= {tx[6:0], 1'b0};
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = ~spi_mode & run & (ack_drive | (tx_en & ~tx[7]));
  assign so_out  = tx[7];
  assign so_oe   = spi_mode & run & ~cs_s;

  tshsp_regmem u_mem (
    .clk     (clk),
    .srst    (srst),
    .wr      (wr),
    .rd_addr (ptr),
    .rd_data (rd_data)
  );

  // Address sampled at the same edge that decides the ack
  logic addr_hit_q;
  always_ff @(posedge clk)
  begin
    addr_hit_q <= addr_hit;
  end

  sequence s_addr_byte_done;
    state == I_ADDR && scl_fall && cnt == CNT_BYTE && !spi_mode;
  endsequence

  sequence s_master_nack;
    state == I_RDATA && scl_fall && cnt == CNT_ACK && mack && !hold &&
      !spi_mode;
  endsequence

  a_por_irq_fall: assert property (@(posedge clk) disable iff (srst)
    $fell(por_busy) |-> $fell(measurement_done_irq))
    else $error("interrupt did not fall at reset release");

  a_reset_hiz: assert property (@(posedge clk) disable iff (srst)
    !run |=> channel_result_oe == '0 && !error_oe)
    else $error("pins driven during reset");

  a_chan_map: assert property (@(posedge clk) disable iff (srst)
    run && $past(run) |-> channel_result_output == $past(channel_judgment))
    else $error("result output does not follow its channel");

  a_addr_match: assert property (@(posedge clk) disable iff (srst)
    s_addr_byte_done |=> ack_drive == addr_hit_q)
    else $error("address ack does not match own address");

  a_ignore_quiet: assert property (@(posedge clk) disable iff (srst)
    state == I_IGNORE && !spi_mode |-> !sda_oe)
    else $error("data line driven while ignoring transfer");

  a_nack_stop: assert property (@(posedge clk) disable iff (srst)
    s_master_nack |=> state == I_IGNORE && !tx_en)
    else $error("read continued after master not-ack");

  a_wr_incr: assert property (@(posedge clk) disable iff (srst)
    wr.en |-> ptr == next_addr(wr.addr))
    else $error("pointer did not advance after write");

  a_mode_sticky: assert property (@(posedge clk) disable iff (srst)
    spi_mode && !hold |=> spi_mode)
    else $error("four-wire mode dropped without reset");

  a_so_release: assert property (@(posedge clk) disable iff (srst)
    cs_s |-> !so_oe)
    else $error("serial output driven while deselected");

  a_irq_done: assert property (@(posedge clk) disable iff (srst)
    !por_busy && meas_done |=> measurement_done_irq [*1] ##0 !por_busy)
    else $error("interrupt missing after measurement pass");
endmodule // tshsp_top

//--- tshsp_host.sv
// Host master model for the two-wire and four-wire links
`timescale 1ns/1ns
module tshsp_host
(
  // Pacing clock
  input  wire logic clk,
  // Device side
  input  wire logic dev_sda_oe,
  input  wire logic so_out,
  output logic      scl_sck,
  output logic      sda_si,
  output logic      cs_n
);
  logic drv_low = 1'b0;
  logic si_q    = 1'b1;
  logic cpol    = 1'b0;
  logic r;
  initial scl_sck = 1'b1;
  initial cs_n = 1'b1;
  // Pull-up on the shared data line while not selected
  assign sda_si = cs_n ? ~(drv_low | dev_sda_oe) : si_q;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Long low phase leaves room for the device to drop its ack
  task automatic start();
    drv_low = 1'b0;
    tick(6);
    scl_sck = 1'b1;
    tick(4);
    drv_low = 1'b1;
    tick(4);
    scl_sck = 1'b0;
    tick(4);
  endtask
  task automatic stop();
    drv_low = 1'b1;
    tick(4);
    scl_sck = 1'b1;
    tick(4);
    drv_low = 1'b0;
    tick(6);
  endtask
  task automatic bitx(input logic b, output logic q);
    drv_low = ~b;
    tick(4);
    scl_sck = 1'b1;
    tick(2);
    q = sda_si;
    tick(2);
    scl_sck = 1'b0;
    tick(2);
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  // Master acks every byte but the last, which gets a not-ack
  task automatic rd_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(last, r);
  endtask
  task automatic spi_begin(input logic m3);
    cpol = m3;
    scl_sck = m3;
    tick(4);
    cs_n = 1'b0;
    tick(4);
  endtask
  task automatic spi_byte(input logic [7:0] b, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
    begin
      scl_sck = 1'b0;
      si_q = b[i];
      tick(4);
      scl_sck = 1'b1;
      tick(3);
      d[i] = so_out;
      tick(1);
    end
  endtask
  // Input bit is inverted at release; the line shows it only once selected again
  task automatic spi_end();
    scl_sck = cpol;
    tick(4);
    cs_n = 1'b1;
    si_q = ~si_q;
    tick(6);
  endtask
endmodule // tshsp_host

//--- tb.sv
// Self-checking bench for the host serial port
`timescale 1ns/1ns
module tb;
  import tshsp_pkg::*;
  localparam int POR = 20;
  logic        clk = 0, srst = 1, ext_n = 1, sa = 0;
  logic        mdone = 0, mstart = 0, err = 0, ack;
  logic        sda_oe, so_out, so_oe, irq, err_out, scl, sda, cs_n;
  logic [7:0]  judg = 8'h00, res, res_oe, d;
  logic [7:0]  mem [128];
  logic [6:0]  p, sl;
  logic [31:0] seed = 32'h21;
  int          bad_count = 0, n_checks = 0, n;
  always #10 clk = ~clk;
  tshsp_top #(.POR_CYCLES(POR)) u_dut (.clk(clk), .srst(srst),
    .external_reset_n(ext_n), .scl_sck(scl), .sda_si_in(sda),
    .sda_out(), .sda_oe(sda_oe), .address_select_pin(sa),
    .so_out(so_out), .so_oe(so_oe), .iface_select_chip_select_n(cs_n),
    .meas_done(mdone), .meas_start(mstart), .channel_judgment(judg),
    .error_status(err), .measurement_done_irq(irq),
    .channel_result_output(res), .channel_result_oe(res_oe),
    .error_out(err_out), .error_oe(), .sense_drive_en());
  tshsp_host u_host (.clk(clk), .dev_sda_oe(sda_oe), .so_out(so_out),
    .scl_sck(scl), .sda_si(sda), .cs_n(cs_n));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input string s, input logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic tw_addr(input logic [6:0] a, input logic rw, logic e);
    u_host.start();
    u_host.wr_byte({a, rw}, ack);
    chk("address ack", {7'h00, e}, {7'h00, ack});
  endtask
  task automatic tw_wr(input int k);
    tw_addr(sl, 1'b0, 1'b1);
    u_host.wr_byte({1'b0, p}, ack);
    for (int i = 0; i < k; i++)
    begin
      d = rnd();
      mem[p + i[6:0]] = d;
      chk("write ack", 8'h01, {7'h00, ack});
      u_host.wr_byte(d, ack);
    end
    chk("last ack", 8'h01, {7'h00, ack});
    u_host.stop();
  endtask
  task automatic tw_rd(input int k);
    tw_addr(sl, 1'b0, 1'b1);
    u_host.wr_byte({1'b0, p}, ack);
    tw_addr(sl, 1'b1, 1'b1);
    for (int i = 0; i < k; i++)
    begin
      u_host.rd_byte(i == k - 1, d);
      chk("two-wire read", mem[p + i[6:0]], d);
    end
    u_host.stop();
  endtask
  task automatic spi(input logic rd, input logic m3, input int k);
    u_host.spi_begin(m3);
    u_host.spi_byte({rd, p}, d);
    for (int i = 0; i < k; i++)
    begin
      if (!rd)
        mem[p + i[6:0]] = rnd();
      u_host.spi_byte(mem[p + i[6:0]], d);
      if (rd)
        chk("four-wire read", mem[p + i[6:0]], d);
    end
    u_host.spi_end();
    chk("so released", 8'h00, {7'h00, so_oe});
  endtask
  initial
  begin
    cyc(8);
    chk("irq in reset", 8'h01, {7'h00, irq});
    chk("oe in reset", 8'h00, res_oe);
    srst = 0;
    n = 0;
    while (irq === 1'b1 && n < 100)
    begin
      cyc(1);
      n++;
    end
    if (n == 100)
    begin
      bad_count++;
      close_out();
    end
    chk("reset length", POR, n[7:0]);
    cyc(1);
    chk("result oe", 8'hFF, res_oe);
    $display("test reset done");
    repeat (8)
    begin
      judg = rnd();
      err = judg[3];
      cyc(1);
      chk("result", judg, res);
      chk("error", {7'h00, judg[3]}, {7'h00, err_out});
    end
    for (int i = 0; i < 2; i++)
    begin
      mdone = 1'b1;
      mstart = i[0];
      cyc(1);
      mdone = 1'b0;
      mstart = 1'b0;
      cyc(1);
      chk("irq set", 8'h01, {7'h00, irq});
      mstart = 1'b1;
      cyc(1);
      mstart = 1'b0;
      cyc(1);
      chk("irq clear", 8'h00, {7'h00, irq});
    end
    $display("test outputs done");
    for (int s = 0; s < 2; s++)
    begin
      sa = s[0];
      sl = sa ? 7'h17 : 7'h16;
      p = sa ? 7'h7E : rnd() & 8'h7F;
      cyc(4);
      tw_wr(3);
      tw_rd(3);
      tw_addr(sa ? 7'h16 : 7'h17, 1'b0, 1'b0);
      u_host.wr_byte(8'h00, ack);
      chk("ignored ack", 8'h00, {7'h00, ack});
      u_host.stop();
    end
    $display("test two-wire done");
    p = rnd() & 8'h7F;
    spi(1'b0, 1'b0, 4);
    spi(1'b1, 1'b1, 4);
    tw_addr(sl, 1'b0, 1'b0);
    u_host.stop();
    $display("test four-wire done");
    ext_n = 1'b0;
    cyc(5);
    chk("oe ext reset", 8'h00, res_oe);
    ext_n = 1'b1;
    cyc(5);
    chk("oe running", 8'hFF, res_oe);
    tw_addr(sl, 1'b0, 1'b1);
    u_host.stop();
    $display("test external reset done");
    close_out();
  end
endmodule // tb
